// ==== hw/afl_alu_flags.sv ====
//----------------------------------------------------------------------
// afl_alu_flags - alu status flag register with apb access
//----------------------------------------------------------------------
// Purpose: computes alu results and keeps the n, ov, z, dc, c flags
// Assumes: exec_i and apb inputs synchronous to mclk_i
// Notes:   core update wins over an apb write in the same cycle
//
// Operation
// - flag-affecting op aimed at flag register keeps logic flag values
// - clear-file on flag register sets zero flag, keeps other four
// - subtract adds two's complement; c and dc act as inverted borrow
// - flag register bits 7 to 5 read as zero
// - negative flag follows result msb
// - overflow flag set when signed result changes sign wrongly
// - zero flag set when result is zero, else cleared
// - add/sub digit carry from bit 3 into bit 4
// - add/sub carry out of result msb
// - rotates load digit carry from source bit 4 or bit 3
// - rotates load carry with the bit shifted out
// - indexed literal offset mode only with extended set enabled
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "afl_cfg.svh"

module afl_alu_flags
    import afl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire afl_apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire afl_exec_s exec_i,
    input wire afl_mode_e mode_req_i,
    output logic [7:0] result_o,
    output logic result_valid_o,
    output logic [7:0] flags_o,
    output logic mode_ok_o
);

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------

    // 8-bit add with carry in: {carry, digit carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic cin);
        logic [8:0] s;
        logic [4:0] lo;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {s[8], lo[4], s[7:0]};
    endfunction

    // apb register address match
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        return a == ofs;
    endfunction

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------

    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    logic rvalid_q;
    logic xen_q;
    logic mode_ok_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [4:0] mask;
    logic [4:0] fnew;
    logic [9:0] sum;
    logic [7:0] sub_b;
    logic apb_acc;
    logic apb_wr;

    //------------------------------------------------------------------
    // alu datapath
    //------------------------------------------------------------------

    // subtract adds the inverted operand plus one
    assign sub_b = ~exec_i.opb;
    assign sum = (exec_i.op == AFL_SUB) ? add8(exec_i.opa, sub_b, 1'b1)
                                        : add8(exec_i.opa, exec_i.opb, 1'b0);

    // result and flag candidates per operation
    always_comb begin
        result_d = exec_i.opa;
        fnew = flags_q;
        mask = `AFL_MASK_NONE;
        unique case (exec_i.op)
            AFL_ADD, AFL_SUB: begin
                result_d = sum[7:0];
                mask = `AFL_MASK_ARITH;
                fnew[`AFL_C_BIT] = sum[9];
                fnew[`AFL_DC_BIT] = sum[8];
                // sign flips against like-signed operands
                fnew[`AFL_OV_BIT] = (exec_i.opa[7] == (exec_i.op == AFL_SUB
                    ? sub_b[7] : exec_i.opb[7])) &&
                    (sum[7] != exec_i.opa[7]);
            end
            AFL_ROT_RIGHT: begin
                result_d = {flags_q[`AFL_C_BIT], exec_i.opa[7:1]};
                mask = `AFL_MASK_ROT | `AFL_MASK_NONE;
                fnew[`AFL_C_BIT] = exec_i.opa[0];
                fnew[`AFL_DC_BIT] = exec_i.opa[4];
            end
            AFL_ROT_LEFT: begin
                result_d = {exec_i.opa[6:0], flags_q[`AFL_C_BIT]};
                mask = `AFL_MASK_ROT;
                fnew[`AFL_C_BIT] = exec_i.opa[7];
                fnew[`AFL_DC_BIT] = exec_i.opa[3];
            end
            AFL_AND: begin
                result_d = exec_i.opa & exec_i.opb;
                mask = `AFL_MASK_LOGIC;
            end
            AFL_OR: begin
                result_d = exec_i.opa | exec_i.opb;
                mask = `AFL_MASK_LOGIC;
            end
            AFL_XOR: begin
                result_d = exec_i.opa ^ exec_i.opb;
                mask = `AFL_MASK_LOGIC;
            end
            AFL_CLEAR: begin
                result_d = `AFL_BYTE_RST;
                mask = `AFL_MASK_ZERO;
            end
            AFL_BIT_CLEAR: result_d = exec_i.opa & ~(8'h01 << exec_i.bit_sel);
            AFL_BIT_SET: result_d = exec_i.opa | (8'h01 << exec_i.bit_sel);
            AFL_SWAP: result_d = {exec_i.opa[3:0], exec_i.opa[7:4]};
            AFL_NOP, AFL_MOVE: result_d = exec_i.opa;
            default: result_d = exec_i.opa;
        endcase
        fnew[`AFL_N_BIT] = result_d[7];
        fnew[`AFL_Z_BIT] = (result_d == 8'h00);
    end

    //------------------------------------------------------------------
    // flag register
    //------------------------------------------------------------------

    assign apb_acc = apb_i.psel && apb_i.penable && pready_q;
    assign apb_wr = apb_acc && apb_i.pwrite;

    // affected bits from flag logic; a direct write lands only when no flag is affected
    always_comb begin
        flags_d = flags_q;
        if (exec_i.valid) begin
            if (exec_i.dest_flags && mask == `AFL_MASK_NONE) begin
                // no flag affected: the result lands on the flag bits
                flags_d = result_d[4:0];
            end else begin
                // all five bits write-blocked, logic values kept
                flags_d = (flags_q & ~mask) | (fnew & mask);
            end
        end else if (apb_wr && hit(apb_i.paddr, `AFL_OFS_FLAGS)) begin
            flags_d = apb_i.pwdata[4:0];
        end
    end

    // flags and result share the execute edge
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_q <= `AFL_FLAGS_RST;
            result_q <= `AFL_BYTE_RST;
            rvalid_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            rvalid_q <= exec_i.valid;
            if (exec_i.valid) begin
                result_q <= result_d;
            end
        end
    end

    //------------------------------------------------------------------
    // config and addressing mode check
    //------------------------------------------------------------------

    // extended set enable bit written by software
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            xen_q <= `AFL_CFG_RST;
        end else if (apb_wr && hit(apb_i.paddr, `AFL_OFS_CFG)) begin
            xen_q <= apb_i.pwdata[`AFL_XEN_BIT];
        end
    end

    // indexed mode allowed only when extended set is on
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mode_ok_q <= 1'b0;
        end else begin
            unique case (mode_req_i)
                AFL_INHERENT, AFL_LITERAL, AFL_DIRECT, AFL_INDIRECT: begin
                    mode_ok_q <= 1'b1;
                end
                AFL_INDEXED: begin
                    mode_ok_q <= xen_q;
                end
                default: begin
                    mode_ok_q <= 1'b0;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // apb slave: one wait state, error on unmapped address
    //------------------------------------------------------------------

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `AFL_WORD_RST;
        end else if (apb_i.psel && apb_i.penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q <= `AFL_WORD_RST;
            if (hit(apb_i.paddr, `AFL_OFS_FLAGS)) begin
                prdata_q <= {27'h000_0000, flags_q};
            end else if (hit(apb_i.paddr, `AFL_OFS_CFG)) begin
                prdata_q <= {31'h0000_0000, xen_q};
            end else if (hit(apb_i.paddr, `AFL_OFS_RESULT)) begin
                prdata_q <= {24'h00_0000, result_q};
            end else begin
                pslverr_q <= 1'b1;
            end
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // outputs straight from flops
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign result_o = result_q;
    assign result_valid_o = rvalid_q;
    assign flags_o = {3'b000, flags_q};
    assign mode_ok_o = mode_ok_q;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_exec_op(afl_op_e o);
        exec_i.valid && exec_i.op == o;
    endsequence

    sequence s_cfg_off;
        !xen_q ##1 !xen_q;
    endsequence

    property p_unimpl_zero;
        flags_o[7:5] == 3'b000 && (!pready_o || prdata_o[31:8] == 24'h00_0000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented flag bits not zero");

    property p_flag_follow;
        exec_i.valid && !exec_i.dest_flags && exec_i.op inside
            {AFL_ADD, AFL_SUB, AFL_AND, AFL_OR, AFL_XOR}
        |=> result_valid_o && flags_o[`AFL_N_BIT] == result_o[7]
            && flags_o[`AFL_Z_BIT] == (result_o == 8'h00);
    endproperty
    a_flag_follow: assert property (p_flag_follow)
        else $error("n or z flag does not match result");

    property p_add_carry;
        s_exec_op(AFL_ADD) |=> flags_o[`AFL_C_BIT] ==
            (({1'b0, $past(exec_i.opa)} + {1'b0, $past(exec_i.opb)}) > 9'h0ff)
            && flags_o[`AFL_DC_BIT] ==
            (({1'b0, $past(exec_i.opa[3:0])} +
              {1'b0, $past(exec_i.opb[3:0])}) > 5'h0f);
    endproperty
    a_add_carry: assert property (p_add_carry)
        else $error("add carry or digit carry wrong");

    property p_sub_borrow;
        s_exec_op(AFL_SUB) |=> flags_o[`AFL_C_BIT] ==
            ($past(exec_i.opa) >= $past(exec_i.opb))
            && result_o == 8'($past(exec_i.opa) - $past(exec_i.opb));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("subtract borrow polarity wrong");

    property p_add_ovf;
        s_exec_op(AFL_ADD) |=> flags_o[`AFL_OV_BIT] ==
            ($past(exec_i.opa[7]) == $past(exec_i.opb[7]) &&
             result_o[7] != $past(exec_i.opa[7]));
    endproperty
    a_add_ovf: assert property (p_add_ovf)
        else $error("overflow flag wrong on add");

    property p_rot_right;
        s_exec_op(AFL_ROT_RIGHT) |=>
            flags_o[`AFL_C_BIT] == $past(exec_i.opa[0])
            && flags_o[`AFL_DC_BIT] == $past(exec_i.opa[4]);
    endproperty
    a_rot_right: assert property (p_rot_right)
        else $error("rotate right carry load wrong");

    property p_clear_flags;
        exec_i.valid && exec_i.op == AFL_CLEAR && exec_i.dest_flags
        |=> flags_o == {3'b000, $past(flags_o[4:3]), 1'b1,
                        $past(flags_o[1:0])};
    endproperty
    a_clear_flags: assert property (p_clear_flags)
        else $error("clear of flag register wrong");

    property p_write_blocked;
        exec_i.valid && exec_i.dest_flags && exec_i.op == AFL_AND
        |=> flags_o[2:0] == {result_o == 8'h00, $past(flags_o[1:0])};
    endproperty
    a_write_blocked: assert property (p_write_blocked)
        else $error("flag write not blocked");

    property p_indexed_off;
        s_cfg_off ##0 mode_req_i == AFL_INDEXED |=> !mode_ok_o;
    endproperty
    a_indexed_off: assert property (p_indexed_off)
        else $error("indexed mode allowed without extended set");

    property p_apb_answer;
        apb_i.psel && apb_i.penable && !pready_o |=> pready_o ##1 !pready_o;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer timing wrong");

endmodule
`default_nettype wire

// ==== hw/afl_cfg.svh ====
//----------------------------------------------------------------------
// afl_cfg.svh - constants of the alu status flag block
//----------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and flag masks
// Assumes: included by its bare name, after afl_pkg
// Notes:   definitions only
`ifndef AFL_CFG_SVH
`define AFL_CFG_SVH

// register byte offsets on the apb side
`define AFL_OFS_FLAGS 12'h000
`define AFL_OFS_CFG 12'h004
`define AFL_OFS_RESULT 12'h008

// flag register field positions
`define AFL_C_BIT 0
`define AFL_DC_BIT 1
`define AFL_Z_BIT 2
`define AFL_OV_BIT 3
`define AFL_N_BIT 4
`define AFL_FLAG_W 5

// config register field positions
`define AFL_XEN_BIT 0

// reset values
`define AFL_FLAGS_RST 5'h00
`define AFL_CFG_RST 1'h0
`define AFL_BYTE_RST 8'h00
`define AFL_WORD_RST 32'h0000_0000

// flag masks per operation class (bits c, dc, z, ov, n)
`define AFL_MASK_NONE 5'h00
`define AFL_MASK_ARITH 5'h1f
`define AFL_MASK_ROT 5'h17
`define AFL_MASK_LOGIC 5'h14
`define AFL_MASK_ZERO 5'h04

`endif

// ==== hw/afl_pkg.sv ====
//----------------------------------------------------------------------
// afl_pkg - types of the alu status flag block
//----------------------------------------------------------------------
// Purpose: operation codes, addressing modes and carrier structs
// Assumes: nothing
// Notes:   constants live in afl_cfg.svh
package afl_pkg;

    // operations presented by the core execute stage
    typedef enum logic [3:0] {
        AFL_NOP = 4'h0,
        AFL_ADD = 4'h1,
        AFL_SUB = 4'h2,
        AFL_ROT_RIGHT = 4'h3,
        AFL_ROT_LEFT = 4'h4,
        AFL_AND = 4'h5,
        AFL_OR = 4'h6,
        AFL_XOR = 4'h7,
        AFL_CLEAR = 4'h8,
        AFL_BIT_CLEAR = 4'h9,
        AFL_BIT_SET = 4'ha,
        AFL_SWAP = 4'hb,
        AFL_MOVE = 4'hc
    } afl_op_e;

    // data addressing modes, one-hot
    typedef enum logic [4:0] {
        AFL_INHERENT = 5'b00001,
        AFL_LITERAL = 5'b00010,
        AFL_DIRECT = 5'b00100,
        AFL_INDIRECT = 5'b01000,
        AFL_INDEXED = 5'b10000
    } afl_mode_e;

    // one execute request from the core
    typedef struct packed {
        logic valid;
        afl_op_e op;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [2:0] bit_sel;
        logic dest_flags;
    } afl_exec_s;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } afl_apb_req_s;

endpackage

// ==== tb/afl_core_model.sv ====
//----------------------------------------------------------------------
// afl_core_model - execute stage of the core, far side of the block
//----------------------------------------------------------------------
// Purpose: presents one instruction per call on the execute port
// Assumes: bench calls issue from a process synced to mclk_i
// Notes:   valid is a one-cycle pulse, fields held for that cycle
`timescale 1ns/1ns
`default_nettype none

module afl_core_model
    import afl_pkg::*;
(
    input wire logic mclk_i,
    output var afl_exec_s exec_o
);
    // idle execute port at time zero
    initial begin
        exec_o = '0;
    end

    // one instruction; dst sends any op to the flag register, bit_sel fixed at zero
    task automatic issue(input afl_op_e op, input logic [7:0] a,
                         input logic [7:0] b, input logic dst);
        @(posedge mclk_i);
        exec_o <= '{1'b1, op, a, b, 3'h0, dst};
        @(posedge mclk_i);
        exec_o <= '0;
    endtask
endmodule
`default_nettype wire

// ==== tb/alu_status_flags_bench.sv ====
//----------------------------------------------------------------------
// alu_status_flags_bench - self-checking bench of the flag block
//----------------------------------------------------------------------
// Purpose: drives apb and execute traffic, compares with a model
// Assumes: one wait state apb slave, one cycle execute latency
// Notes:   flags start at zero after reset
`timescale 1ns/1ns
`default_nettype none
`include "afl_cfg.svh"

module alu_status_flags_bench
    import afl_pkg::*;
;
    logic mclk_i;
    logic rst_i;
    afl_apb_req_s apb;
    afl_exec_s exec;
    afl_mode_e mode_req;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [7:0] result_o;
    logic [7:0] flags_o;
    logic result_valid_o;
    logic mode_ok_o;
    int error_cnt;
    int checks_done;
    logic [4:0] fl;
    logic [7:0] lr;
    logic [31:0] rd;
    logic err;

    //------------------------------------------------------------------
    // clock, design and core model
    //------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    afl_alu_flags uut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_i(apb),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .exec_i(exec), .mode_req_i(mode_req), .result_o(result_o),
        .result_valid_o(result_valid_o), .flags_o(flags_o),
        .mode_ok_o(mode_ok_o));

    afl_core_model core (.mclk_i(mclk_i), .exec_o(exec));

    //------------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // compare one value, report at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [11:0] ad,
                            input logic [31:0] wd, output logic [31:0] q,
                            output logic e);
        int n;
        n = 0;
        @(posedge mclk_i);
        apb <= '{1'b1, 1'b0, wr, ad, wd};
        @(posedge mclk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        q = prdata_o;
        e = pslverr_o;
        apb <= '0;
        if (n >= 20) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    // reference of result and flags {n, ov, z, dc, c}
    function automatic logic [12:0] ref_op(input afl_op_e op,
        input logic [7:0] a, input logic [7:0] b, input logic [4:0] f);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        bb = (op == AFL_SUB) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, op == AFL_SUB};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == AFL_SUB};
        r = s[7:0];
        case (op)
            AFL_ADD, AFL_SUB: return {r, r[7],
                (a[7] == bb[7]) && (r[7] != a[7]), r == 8'h00, h[4], s[8]};
            AFL_ROT_RIGHT: begin
                r = {f[0], a[7:1]};
                return {r, r[7], f[3], r == 8'h00, a[4], a[0]};
            end
            AFL_ROT_LEFT: begin
                r = {a[6:0], f[0]};
                return {r, r[7], f[3], r == 8'h00, a[3], a[7]};
            end
            AFL_AND: begin
                r = a & b;
                return {r, r[7], f[3], r == 8'h00, f[1], f[0]};
            end
            AFL_CLEAR: return {8'h00, f[4:3], 1'b1, f[1:0]};
            default: return {a | 8'h01, a[4:1], 1'b1};
        endcase
    endfunction

    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    task automatic t_reset();
        chk(32'(flags_o), 32'h0000_0000);
        chk(32'(result_o), 32'h0000_0000);
        apb_xfer(1'b0, `AFL_OFS_CFG, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0000);
        apb_xfer(1'b0, 12'h00c, 32'h0000_0000, rd, err);
        chk({rd[30:0], err}, 32'h0000_0001);
    endtask

    // arithmetic, rotate and flag-destination rows back to back
    task automatic t_exec_table();
        afl_op_e ops [14] = '{AFL_ADD, AFL_ADD, AFL_ADD, AFL_SUB, AFL_SUB,
            AFL_SUB, AFL_SUB, AFL_ROT_RIGHT, AFL_ROT_LEFT, AFL_ROT_RIGHT,
            AFL_AND, AFL_ADD, AFL_CLEAR, AFL_BIT_SET};
        logic [7:0] av [14] = '{8'h7f, 8'hff, 8'h08, 8'h05, 8'h00, 8'h80,
            8'h10, 8'h11, 8'h88, 8'h01, 8'hf0, 8'h7f, 8'h00, 8'h00};
        logic [7:0] bv [14] = '{8'h01, 8'h01, 8'h08, 8'h05, 8'h01, 8'h01,
            8'h01, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h01, 8'h00, 8'h00};
        logic [13:0] dv = 14'h3c00;
        logic [12:0] e;
        logic [7:0] a;
        for (int i = 0; i < 14; i++) begin
            a = (ops[i] == AFL_BIT_SET) ? {3'h0, fl} : av[i];
            e = ref_op(ops[i], a, bv[i], fl);
            core.issue(ops[i], a, bv[i], dv[i]);
            #1;
            chk(32'(result_o), 32'(e[12:5]));
            chk(32'(flags_o), 32'(e[4:0]));
            chk(32'(flags_o), 32'(e[4:0]));
            chk(32'(result_valid_o), 32'h0000_0001);
            fl = e[4:0];
            lr = e[12:5];
        end
    endtask

    // unimplemented bits and the read-only result word
    task automatic t_regs();
        apb_xfer(1'b1, `AFL_OFS_FLAGS, 32'h0000_00ff, rd, err);
        apb_xfer(1'b0, `AFL_OFS_FLAGS, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_001f);
        chk(32'(flags_o), 32'h0000_001f);
        apb_xfer(1'b1, `AFL_OFS_RESULT, 32'h0000_0055, rd, err);
        apb_xfer(1'b0, `AFL_OFS_RESULT, 32'h0000_0000, rd, err);
        chk(rd, 32'(lr));
    endtask

    // every addressing mode with the extended set off and on
    task automatic t_modes();
        afl_mode_e m;
        int ex;
        for (int x = 0; x < 2; x++) begin
            apb_xfer(1'b1, `AFL_OFS_CFG, 32'(x), rd, err);
            for (int k = 0; k < 6; k++) begin
                m = (k < 5) ? afl_mode_e'(5'h01 << k) : afl_mode_e'(5'h03);
                @(posedge mclk_i);
                mode_req <= m;
                repeat (2) @(posedge mclk_i);
                #1;
                ex = (k < 4 || (k == 4 && x == 1)) ? 1 : 0;
                chk(32'(mode_ok_o), 32'(ex));
            end
        end
    endtask

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        error_cnt = 0;
        checks_done = 0;
        fl = 5'h00;
        lr = 8'h00;
        rst_i = 1'b1;
        apb = '0;
        mode_req = AFL_INHERENT;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        t_reset();
        t_exec_table();
        t_regs();
        t_modes();
        tally_and_finish();
    end
endmodule
`default_nettype wire
